/* hdl/ssr_device.sv */
// memory end: 64K x 4 array with registered address and late write abort

// Functional notes
// R1 - 65536 words of 4 bits, shared pins
// R2 - address and write select registered each edge
// R3 - write select high reads, low writes
// R4 - write stores only if strobe asserted
// R5 - controller lifts strobe early to abort
// R6 - strobe and output enable act directly
// R7 - read drives when enabled, write floats
// R8 - one set of pins, controller releases
// R9 - single clock sequences everything
// R10 - first read after write re-enables drivers
// R11 - write after read floats drivers
// R12 - data valid at completing edge, registered address
// R13 - aborted write leaves word unchanged

// cycle timing, one rising edge per step
//   edge n   : address and write select registered
//   cycle n  : read cycle drives the registered word while output enable is low
//   cycle n  : write cycle floats the pins; controller drives data and strobe
//   edge n+1 : write stored if the strobe is low, otherwise aborted
//   edge n+1 : next address and select registered as usual
// a read after a write turns the drivers on at its own edge
// a write after a read turns them off at its own edge
// a same-edge write to the read address is forwarded to the read word
// idle controller cycles register as reads of the held address
// memory contents are not reset; only the registers are
// clock enable low freezes registers and blocks stores
// output enable and strobe are not registered
// limitation: a strobe cut between edges is seen only at the edge

module ssr_device (
   // clock and reset
   input  wire logic core_clk,
   input  wire logic reset,
   // clock enable: low freezes every register
   input  wire logic clk_en,
   // link
   ssr_link_if.device link
);
   // registered view of the synchronous inputs
   logic [ssr_pkg::ADDR_W-1:0] addr_r;
   ssr_pkg::ssr_state_type     cycle_r;
   ssr_pkg::ssr_state_type     prev_cycle_r;

   // cycle decode and turnaround flags
   logic                       read_cycle;
   logic                       write_cycle;
   logic                       turn_on;
   logic                       turn_off;

   // asynchronous controls and drive decision
   logic                       strobe_on;
   logic                       drive_allowed;
   logic                       drive_cycle;
   logic                       drive_on;

   // write path
   logic                       store_now;
   logic [ssr_pkg::DATA_W-1:0] store_data;

   // read path
   logic [ssr_pkg::DATA_W-1:0] array_word;
   logic [ssr_pkg::DATA_W-1:0] next_word;
   logic                       bypass_hit;
   logic [ssr_pkg::DATA_W-1:0] rd_data_r;

   // address taken at every enabled rising edge  [R2] [R9]
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         addr_r <= ssr_pkg::ADDR_RST;
      end else if (clk_en) begin
         addr_r <= link.word_address_inputs;
      end
   end

   // cycle type taken from the write select level at the same edge  [R2] [R3]
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         cycle_r <= ssr_pkg::SSR_IDLE;
      end else if (clk_en) begin
         if (link.sync_write_select_n) begin
            cycle_r <= ssr_pkg::SSR_READ; // [R3]
         end else begin
            cycle_r <= ssr_pkg::SSR_WRITE; // [R3]
         end
      end
   end

   // previous cycle type, kept to spot the bus turnarounds
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         prev_cycle_r <= ssr_pkg::SSR_IDLE;
      end else if (clk_en) begin
         prev_cycle_r <= cycle_r;
      end
   end

   // decode of the registered cycle; idle only until the first enabled edge after reset
   always_comb begin
      read_cycle  = 1'b0;
      write_cycle = 1'b0;
      case (cycle_r)
         ssr_pkg::SSR_IDLE: begin
            read_cycle  = 1'b0;
            write_cycle = 1'b0;
         end
         ssr_pkg::SSR_READ: begin
            read_cycle  = 1'b1;
         end
         ssr_pkg::SSR_WRITE: begin
            write_cycle = 1'b1;
         end
         default: begin
            read_cycle  = 1'b0;
            write_cycle = 1'b0;
         end
      endcase
   end

   // strobe and output enable used straight from the pins, never registered  [R6]
   assign strobe_on     = !link.async_write_strobe_n;
   assign drive_allowed = !link.output_enable_n;

   // a write lands only with the strobe low at the completing edge  [R4] [R13]
   // strobe high there is an abort: the word keeps its old value
   always_comb begin
      store_now = 1'b0;
      if (clk_en && write_cycle) begin
         if (strobe_on) begin
            store_now = 1'b1; // [R4]
         end else begin
            store_now = 1'b0; // [R13]
         end
      end
   end
   assign store_data = link.shared_data_pins; // [R8] [R12]

   // one storage column per data pin, each lane holding its own bit  [R1]
   for (genvar lane = 0; lane < ssr_pkg::DATA_W; lane++) begin : g_lane
      logic col [0:ssr_pkg::WORDS-1];
      // store at the address registered for the write cycle  [R12]
      always_ff @(posedge core_clk) begin
         if (store_now) begin
            col[addr_r] <= store_data[lane];
         end
      end
      // column read at the address arriving for the next cycle
      assign array_word[lane] = col[link.word_address_inputs];
   end

   // same-edge store to the incoming address; forwarded so no stale word is read
   assign bypass_hit = store_now && (addr_r == link.word_address_inputs);

   // word to register for the next read cycle
   always_comb begin
      next_word = array_word;
      if (bypass_hit) begin
         next_word = store_data;
      end
   end

   // read word registered at the edge that registers the read, so pins come from flops
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         rd_data_r <= ssr_pkg::DATA_RST;
      end else if (clk_en) begin
         rd_data_r <= next_word;
      end
   end

   // turnarounds: read after write turns drivers on, write after read turns them off
   always_comb begin
      turn_on  = 1'b0;
      turn_off = 1'b0;
      if (read_cycle && (prev_cycle_r == ssr_pkg::SSR_WRITE)) begin
         turn_on = 1'b1; // [R10]
      end
      if (write_cycle && (prev_cycle_r != ssr_pkg::SSR_WRITE)) begin
         turn_off = 1'b1; // [R11]
      end
   end

   // drive wanted for this cycle; both turnarounds settle at the edge itself
   always_comb begin
      drive_cycle = 1'b0;
      if (turn_on) begin
         drive_cycle = 1'b1;
      end else if (turn_off) begin
         drive_cycle = 1'b0;
      end else begin
         drive_cycle = read_cycle; // [R7]
      end
   end

   // output enable gates the drivers directly, with no clock in the path
   always_comb begin
      drive_on = 1'b0;
      if (drive_allowed) begin
         drive_on = drive_cycle; // [R6] [R7]
      end
   end

   // drivers off in every write cycle leave the pins to the controller  [R8]
   assign link.dev_data_o  = rd_data_r;
   assign link.dev_data_oe = drive_on;
endmodule

/* hdl/ssr_pkg.sv */
// shared constants and types for the late-write-abort synchronous memory link
package ssr_pkg;
   localparam int ADDR_W     = 16;
   localparam int DATA_W     = 4;
   localparam int WORDS      = 65536;
   localparam logic [15:0] ADDR_RST = 16'h0000;
   localparam logic [3:0]  DATA_RST = 4'h0;
   localparam int REQ_CYCLES = 1;
   typedef enum logic [1:0] {
      SSR_IDLE,
      SSR_READ,
      SSR_WRITE
   } ssr_state_type;
endpackage

/* hdl/ssr_link_if.sv */
// pin-level link between the memory device and its controller
interface ssr_link_if;
   // synchronous controls
   logic [15:0] word_address_inputs;
   logic        sync_write_select_n;
   // asynchronous controls
   logic        async_write_strobe_n;
   logic        output_enable_n;
   // shared data pins, split into per-end drive
   logic [3:0]  dev_data_o;
   logic        dev_data_oe;
   logic [3:0]  ctl_data_o;
   logic        ctl_data_oe;
   logic [3:0]  shared_data_pins;

   // wire level resolved from the enables; contention or float shows as unknown
   assign shared_data_pins = (dev_data_oe && !ctl_data_oe) ? dev_data_o :
                             (ctl_data_oe && !dev_data_oe) ? ctl_data_o : 4'hX;

   modport device (
      input  word_address_inputs,
      input  sync_write_select_n,
      input  async_write_strobe_n,
      input  output_enable_n,
      input  shared_data_pins,
      output dev_data_o,
      output dev_data_oe
   );

   modport controller (
      output word_address_inputs,
      output sync_write_select_n,
      output async_write_strobe_n,
      output output_enable_n,
      input  shared_data_pins,
      output ctl_data_o,
      output ctl_data_oe
   );
endinterface

/* hdl/ssr_controller.sv */
// controller end: issues single read and write cycles with optional abort
module ssr_controller (
   // clock, reset, enable
   input  wire logic        core_clk,
   input  wire logic        reset,
   input  wire logic        clk_en,
   // user request
   input  wire logic        req_valid,
   output logic             req_ready,
   input  wire logic        req_write,
   input  wire logic        req_abort,
   input  wire logic [15:0] req_addr,
   input  wire logic [3:0]  req_wdata,
   input  wire logic        out_enable,
   // user answer
   output logic             rsp_valid,
   output logic [3:0]       rsp_rdata,
   // link
   ssr_link_if.controller   link
);
   ssr_pkg::ssr_state_type state_r;
   logic [15:0]            addr_r;
   logic [3:0]             wdata_r;
   logic                   wr_r;
   logic                   abort_r;

   assign req_ready = (state_r == ssr_pkg::SSR_IDLE);

   // one cycle per request: present at edge n, complete at edge n+1
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         state_r <= ssr_pkg::SSR_IDLE;
         addr_r  <= ssr_pkg::ADDR_RST;
         wdata_r <= ssr_pkg::DATA_RST;
         wr_r    <= 1'b0;
         abort_r <= 1'b0;
      end else if (clk_en) begin
         case (state_r)
            ssr_pkg::SSR_IDLE: begin
               if (req_valid) begin
                  addr_r  <= req_addr;
                  wdata_r <= req_wdata;
                  wr_r    <= req_write;
                  abort_r <= req_abort;
                  state_r <= req_write ? ssr_pkg::SSR_WRITE : ssr_pkg::SSR_READ;
               end
            end
            ssr_pkg::SSR_READ,
            ssr_pkg::SSR_WRITE: begin
               state_r <= ssr_pkg::SSR_IDLE;
            end
            default: begin
               state_r <= ssr_pkg::SSR_IDLE;
            end
         endcase
      end
   end

   // address and select stand during the issuing state; idle cycles are reads  [R3]
   assign link.word_address_inputs = addr_r;
   assign link.sync_write_select_n  = !(state_r == ssr_pkg::SSR_WRITE);
   assign link.output_enable_n      = !out_enable;

   // strobe held low for the whole data cycle unless aborted  [R4] [R5]
   logic data_phase_r;
   logic data_wr_r;
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         data_phase_r <= 1'b0;
         data_wr_r    <= 1'b0;
      end else if (clk_en) begin
         data_phase_r <= (state_r != ssr_pkg::SSR_IDLE);
         data_wr_r    <= (state_r == ssr_pkg::SSR_WRITE) && !abort_r;
      end
   end
   assign link.async_write_strobe_n = !data_wr_r;
   // drive write data only while the device floats the pins  [R8] [R12]
   assign link.ctl_data_o  = wdata_r;
   assign link.ctl_data_oe = data_wr_r;

   // read data captured at the edge closing the read's data phase
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         rsp_valid <= 1'b0;
         rsp_rdata <= ssr_pkg::DATA_RST;
      end else if (clk_en) begin
         rsp_valid <= data_phase_r && !wr_r;
         if (data_phase_r && !wr_r) begin
            rsp_rdata <= link.shared_data_pins;
         end
      end
   end
endmodule

/* sim/ssr_link_props.sv */
// protocol checks on the link between memory and controller
module ssr_link_props (
   // clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // link controls and drive enables
   input wire logic sync_write_select_n,
   input wire logic async_write_strobe_n,
   input wire logic output_enable_n,
   input wire logic dev_data_oe,
   input wire logic ctl_data_oe
);
   // one domain, so clock and reset are given once
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   // $past is guarded so values from inside reset never count
   a_write_floats_pins: assert property (!$past(reset) && !$past(sync_write_select_n) |-> !dev_data_oe)
      else $error("device drove pins in write cycle");
   a_read_drive_follows: assert property (!$past(reset) && $past(sync_write_select_n) |->
      dev_data_oe == !output_enable_n) else $error("read drive not tied to enable");
   a_no_pin_clash: assert property (!(dev_data_oe && ctl_data_oe)) else $error("pins driven twice");
   a_strobe_after_select: assert property (!async_write_strobe_n |-> !$past(reset) && !$past(sync_write_select_n))
      else $error("strobe without write select");
   a_strobe_one_cycle: assert property ($fell(async_write_strobe_n) |=> async_write_strobe_n)
      else $error("strobe held too long");
   a_strobe_with_data: assert property (!async_write_strobe_n |-> ctl_data_oe) else $error("strobe, no data");
   a_select_single: assert property ($fell(sync_write_select_n) |=> sync_write_select_n)
      else $error("write select too long");
   a_data_only_write: assert property (ctl_data_oe |-> !$past(reset) && !$past(sync_write_select_n))
      else $error("data driven outside write");
   // main scenarios: completed write, aborted write, write after read turnaround
   c_write: cover property (!sync_write_select_n ##1 !async_write_strobe_n);
   c_abort: cover property (!sync_write_select_n ##1 async_write_strobe_n);
   c_turn: cover property (dev_data_oe ##[1:4] ctl_data_oe);
endmodule

/* sim/testbench.sv */
// self-checking bench joining memory and controller ends
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic            core_clk = 0, reset = 1, req_valid = 0, req_write = 0, req_abort = 0, out_enable = 1;
   logic [15:0]     req_addr = 16'h0000;
   logic [3:0]      req_wdata = 4'h0;
   wire logic       req_ready, rsp_valid;
   wire logic [3:0] rsp_rdata;
   logic [3:0]      mem [logic [15:0]];
   logic [3:0]      exp_q [$];
   logic [15:0]     addrs [32];
   int              n_mismatch = 0, checks = 0, cycles = 0;
   ssr_link_if link_i ();
   ssr_device ssr_device_i (.core_clk(core_clk), .reset(reset), .clk_en(1'b1), .link(link_i));
   ssr_controller ssr_controller_i (.core_clk(core_clk), .reset(reset), .clk_en(1'b1), .req_valid(req_valid),
      .req_ready(req_ready), .req_write(req_write), .req_abort(req_abort), .req_addr(req_addr),
      .req_wdata(req_wdata), .out_enable(out_enable), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .link(link_i));
   ssr_link_props ssr_link_props_i (.core_clk(core_clk), .reset(reset),
      .sync_write_select_n(link_i.sync_write_select_n), .async_write_strobe_n(link_i.async_write_strobe_n),
      .output_enable_n(link_i.output_enable_n), .dev_data_oe(link_i.dev_data_oe), .ctl_data_oe(link_i.ctl_data_oe));
   initial forever #2.5 core_clk = ~core_clk;
   task automatic check(input logic [3:0] seen, input logic [3:0] want);
      checks++;
      if (seen !== want) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h want %h", $time, seen, want);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // one request per call; the model memory is updated as it is issued
   task automatic issue(input logic wr, input logic ab, input logic [15:0] a, input logic [3:0] d);
      repeat (20) if (req_ready !== 1'b1) @(negedge core_clk);
      {req_write, req_abort, req_addr, req_wdata} = {wr, ab, a, d};
      if (!wr) out_enable = 1'b1; // reads must see the device drive
      req_valid = 1'b1;
      if (!wr) exp_q.push_back(mem[a]);
      else if (!ab) mem[a] = d;
      @(negedge core_clk);
      req_valid = 1'b0;
      if (wr) out_enable = 1'($urandom); // only after the last read's data phase has closed
   endtask
   // read answers are compared mid-cycle, where the one-cycle pulse is settled
   always @(negedge core_clk) if (rsp_valid === 1'b1) check(rsp_rdata, exp_q.pop_front());
   // hang guard, far above the few hundred cycles the tests need
   always @(posedge core_clk) if (++cycles == 2000) begin n_mismatch++; end_of_test(); end
   initial begin
      void'($urandom(32'h6449FF13));
      repeat (12) @(negedge core_clk);
      reset = 1'b0;
      // write then read back at once, both end words included
      for (int i = 0; i < 32; i++) begin
         addrs[i] = (i == 0) ? 16'h0000 : (i == 1) ? 16'hFFFF : 16'($urandom);
         issue(1'b1, 1'b0, addrs[i], 4'($urandom));
         issue(1'b0, 1'b0, addrs[i], 4'h0);
      end
      $display("test write_read done");
      // aborted writes of fresh data must leave each of the 32 addressed words as it was
      for (int i = 0; i < 32; i++) begin
         issue(1'b1, 1'b1, addrs[i], 4'($urandom));
         issue(1'b0, 1'b0, addrs[i], 4'h0);
      end
      $display("test abort done");
      repeat (8) @(negedge core_clk);
      check(4'(exp_q.size()), 4'h0);
      end_of_test();
   end
endmodule
